// [bsl_pkg.sv]
// Shared constants, types and field layouts of the four-bit datapath slice.
package bsl_pkg;

   // -------------------------------------------------------------------
   // Widths and field positions
   // -------------------------------------------------------------------
   localparam int SLICE_W     = 4;   // Data bits per slice.
   localparam int ADDR_W      = 3;   // Register address field width.
   localparam int STACK_DEPTH = 16;  // Stack entries per slice.
   localparam int CB_TOP      = 3;   // Control bit three: push/pull, complement, source.
   localparam int CB_AMSB     = 2;   // Top bit of an address field.
   localparam int CB_CTL_LSB  = 2;   // Function field sits in bits 3:2.

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [SLICE_W-1:0] DATA_RST = 4'h0;
   localparam logic               ZERO_N_RST = 1'b1;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   // Eight intervals of one machine cycle, Gray coded along the loop.
   typedef enum logic [2:0] {
      PH_T1 = 3'h0, PH_T2 = 3'h1, PH_T3 = 3'h3, PH_T4 = 3'h2,
      PH_T5 = 3'h6, PH_T6 = 3'h7, PH_T7 = 3'h5, PH_T8 = 3'h4
   } bsl_phase_t;

   typedef enum logic [1:0] {
      ALU_AND = 2'h0, ALU_XOR = 2'h1, ALU_OR = 2'h2, ALU_ADD = 2'h3
   } bsl_alu_t;

   typedef enum logic [1:0] {
      CTL_NOP = 2'h0, CTL_SIGN_FILL = 2'h1, CTL_SHIFT_LEFT_ONE = 2'h2,
      CTL_SHIFT_RIGHT_ONE = 2'h3
   } bsl_ctl_t;

   // Control words gathered over one machine cycle.
   typedef struct packed {
      logic                    push_pull;
      logic [ADDR_W-1:0]       a_addr;
      logic                    comp_a;
      logic [ADDR_W-1:0]       b_addr;
      bsl_ctl_t                ctl;
      bsl_alu_t                alu;
   } bsl_micro_t;

   // Four status flags.
   typedef struct packed {
      logic gen;
      logic carry;
      logic ovf;
      logic link;
   } bsl_flags_t;

   localparam bsl_flags_t FLAGS_RST = 4'h0;

endpackage : bsl_pkg

// [bsl_regfile.sv]
// Working register file: one write port, two registered read ports.
module bsl_regfile #(
   parameter int W  = bsl_pkg::SLICE_W,
   parameter int AW = bsl_pkg::ADDR_W
) (
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic          re_a,
   input  wire logic [AW-1:0] raddr_a,
   output logic      [W-1:0]  rdata_a,
   input  wire logic          re_b,
   input  wire logic [AW-1:0] raddr_b,
   output logic      [W-1:0]  rdata_b
);
   import bsl_pkg::*;

   logic [W-1:0] mem_q [2**AW];

   // Storage has no reset; address zero is never written by the slice.
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   // Read data come out of registers so the word is steady for a whole interval.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_a <= DATA_RST;
         rdata_b <= DATA_RST;
      end else begin
         if (re_a) begin
            rdata_a <= mem_q[raddr_a];
         end
         if (re_b) begin
            rdata_b <= mem_q[raddr_b];
         end
      end
   end

endmodule : bsl_regfile

// [bsl_slice.sv]
// Four-bit datapath slice: control decode, ALU, shifter, stack and flags.
module bsl_slice #(
   parameter int W     = bsl_pkg::SLICE_W,
   parameter int DEPTH = bsl_pkg::STACK_DEPTH
) (
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   input  wire logic                          cycle_start,
   input  wire logic [3:0]                    control_bus_bits,
   input  wire logic                          msb_slice,
   input  wire logic                          upper_byte_slice,
   input  wire logic                          flag_update_en,
   input  wire logic                          link_carry_select,
   input  wire logic                          flag_save_restore,
   input  wire logic                          sign_input,
   input  wire logic [W-1:0]                  external_data_lines_i,
   output logic      [W-1:0]                  external_data_lines_o,
   output logic      [W-1:0]                  external_data_lines_oe,
   input  wire logic                          upper_carry_shift_line_i,
   output logic                               upper_carry_shift_line_o,
   output logic                               upper_carry_shift_line_oe,
   input  wire logic                          lower_carry_shift_line_i,
   output logic                               lower_carry_shift_line_o,
   output logic                               lower_carry_shift_line_oe,
   output logic                               stack_full_out,
   output logic                               result_zero_n,
   output logic                               general_flag_out,
   output logic                               carry_overflow_out,
   output bsl_pkg::bsl_flags_t                flags
);
   import bsl_pkg::*;

   // Flag fields and the stack are laid out for a four-bit slice.
   if (W != SLICE_W) begin : g_w_chk
      $error("bsl_slice serves only four-bit slices");
   end
   if (DEPTH < 2) begin : g_d_chk
      $error("bsl_slice stack needs at least two entries");
   end

   // -------------------------------------------------------------------
   // Interval sequencing
   // -------------------------------------------------------------------
   bsl_phase_t phase_q;
   bsl_phase_t phase_d;

   // One clock per interval; cycle_start forces the next interval to T1.
   always_comb begin
      unique case (phase_q)
         PH_T1: phase_d = PH_T2;
         PH_T2: phase_d = PH_T3;
         PH_T3: phase_d = PH_T4;
         PH_T4: phase_d = PH_T5;
         PH_T5: phase_d = PH_T6;
         PH_T6: phase_d = PH_T7;
         PH_T7: phase_d = PH_T8;
         PH_T8: phase_d = PH_T1;
      endcase
      if (cycle_start) begin
         phase_d = PH_T1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= PH_T1;
      end else begin
         phase_q <= phase_d;
      end
   end

   // -------------------------------------------------------------------
   // Control word capture on the odd intervals
   // -------------------------------------------------------------------
   bsl_micro_t        micro_q;
   logic [ADDR_W-1:0] r_addr_q;
   logic              src_q;          // Bit three of the phase-7 word.

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         micro_q  <= '0;
         r_addr_q <= '0;
         src_q    <= 1'b0;
      end else begin
         unique case (phase_q)
            PH_T1: {micro_q.push_pull, micro_q.a_addr} <= control_bus_bits;
            PH_T3: {micro_q.comp_a, micro_q.b_addr}    <= control_bus_bits;
            PH_T5: {micro_q.ctl, micro_q.alu} <= {bsl_ctl_t'(control_bus_bits[3:2]),
                                                  bsl_alu_t'(control_bus_bits[1:0])};
            PH_T7: {src_q, r_addr_q}                   <= control_bus_bits;
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Register file and operand buses
   // -------------------------------------------------------------------
   logic [W-1:0] rd_a;
   logic [W-1:0] rd_b;
   logic [W-1:0] a_q;
   logic [W-1:0] b_q;
   logic [W-1:0] r_q;
   logic [W-1:0] stk_q [DEPTH];
   bsl_flags_t   flags_q;
   logic         rf_we;

   assign rf_we = (phase_q == PH_T8) && (r_addr_q != '0);

   bsl_regfile #(
      .W  (W),
      .AW (ADDR_W)
   ) u_rf (
      .clk     (clk),
      .arst_n  (arst_n),
      .we      (rf_we),
      .waddr   (r_addr_q),
      .wdata   (r_q),
      .re_a    (phase_q == PH_T1),
      .raddr_a (control_bus_bits[CB_AMSB:0]),
      .rdata_a (rd_a),
      .re_b    (phase_q == PH_T3),
      .raddr_b (control_bus_bits[CB_AMSB:0]),
      .rdata_b (rd_b)
   );

   // A-bus settles at the end of T2, B-bus at the end of T4.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         a_q <= DATA_RST;
         b_q <= DATA_RST;
      end else begin
         if (phase_q == PH_T2) begin
            if (micro_q.a_addr != '0) begin
               a_q <= rd_a;
            end else if (micro_q.push_pull) begin
               a_q <= stk_q[0];
            end else if (flag_save_restore) begin
               a_q <= flags_q;
            end else begin
               a_q <= '0;
            end
         end
         if (phase_q == PH_T4) begin
            b_q <= (micro_q.b_addr != '0) ? rd_b : '0;
         end
      end
   end

   // -------------------------------------------------------------------
   // ALU, evaluated in T5 with the carry rippling through the lower line
   // -------------------------------------------------------------------
   logic [W-1:0] a_eff;
   logic [W:0]   sum_w;
   logic [W-1:0] low_sum;
   logic         v_w;
   logic [W-1:0] alu_w;
   logic [W-1:0] s_q;

   assign a_eff   = micro_q.comp_a ? ~a_q : a_q;
   assign sum_w   = {1'b0, a_eff} + {1'b0, b_q} + {{W{1'b0}}, lower_carry_shift_line_i};
   assign low_sum = {1'b0, a_eff[W-2:0]} + {1'b0, b_q[W-2:0]}
                    + {{(W-1){1'b0}}, lower_carry_shift_line_i};
   assign v_w     = sum_w[W] ^ low_sum[W-1];                 // Carry into top bit differs.

   always_comb begin
      unique case (bsl_alu_t'(control_bus_bits[1:0]))
         ALU_AND: alu_w = a_eff & b_q;
         ALU_XOR: alu_w = a_eff ^ b_q;
         ALU_OR:  alu_w = a_eff | b_q;
         ALU_ADD: alu_w = sum_w[W-1:0];
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= DATA_RST;
      end else if (phase_q == PH_T5) begin
         s_q <= alu_w;
      end
   end

   // -------------------------------------------------------------------
   // Shifter and R-bus source in T7
   // -------------------------------------------------------------------
   logic         link_in_shift;
   logic         msb_in;
   logic [W-1:0] sh_w;
   logic [W-1:0] r_w;
   logic         sign_q;

   assign link_in_shift = msb_slice && link_carry_select;
   assign msb_in        = link_in_shift ? flags_q.link : upper_carry_shift_line_i;

   always_comb begin
      unique case (micro_q.ctl)
         CTL_SHIFT_LEFT_ONE:  sh_w = {s_q[W-2:0], lower_carry_shift_line_i};
         CTL_SHIFT_RIGHT_ONE: sh_w = {msb_in, s_q[W-1:1]};
         default:             sh_w = s_q;
      endcase
      if (micro_q.ctl == CTL_SIGN_FILL) begin
         // Lower-byte slices keep the low byte; upper ones fill with sign or zero.
         r_w = upper_byte_slice ? (control_bus_bits[CB_TOP] ? {W{sign_q}} : '0)
                                : s_q;
      end else begin
         r_w = control_bus_bits[CB_TOP] ? external_data_lines_i : sh_w;
      end
   end

   // The sign line is sampled in T2, before the data lines are reused.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sign_q <= 1'b0;
      end else if (phase_q == PH_T2) begin
         sign_q <= sign_input;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_q <= DATA_RST;
      end else if (phase_q == PH_T7) begin
         r_q <= r_w;
      end
   end

   // Zero-result lags the R-bus register by one interval so the sequencer sees a settled value.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         result_zero_n <= ZERO_N_RST;
      end else if (phase_q == PH_T8) begin
         result_zero_n <= (r_q != '0);
      end
   end

   // -------------------------------------------------------------------
   // Stack: entry zero is the top, the last entry the bottom
   // -------------------------------------------------------------------
   logic do_pop;
   logic do_push;

   assign do_pop  = (phase_q == PH_T2) && (micro_q.a_addr == '0) && micro_q.push_pull;
   assign do_push = (phase_q == PH_T8) && (r_addr_q == '0) && micro_q.push_pull;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            stk_q[i] <= DATA_RST;
         end
      end else if (do_push) begin
         stk_q[0] <= r_q;
         for (int i = 1; i < DEPTH; i++) begin
            stk_q[i] <= stk_q[i-1];
         end
      end else if (do_pop) begin
         stk_q[DEPTH-1] <= '0;   // Bottom empties so stack-full clears after pops.
         for (int i = 0; i < DEPTH-1; i++) begin
            stk_q[i] <= stk_q[i+1];
         end
      end
   end

   assign stack_full_out = (stk_q[DEPTH-1] != '0);

   // -------------------------------------------------------------------
   // Status flags
   // -------------------------------------------------------------------
   logic restore;

   assign restore = (phase_q == PH_T8) && (r_addr_q == '0) && !micro_q.push_pull
                    && flag_save_restore;

   // Add status is taken in T5, shift link in T7, restore from R-bus in T8.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_q <= FLAGS_RST;
      end else if (restore) begin
         flags_q <= r_q;
      end else if (phase_q == PH_T5) begin
         // The ALU code is taken live in T5; the latched copy still holds the last step.
         if (msb_slice && flag_update_en && bsl_alu_t'(control_bus_bits[1:0]) == ALU_ADD) begin
            flags_q.carry <= sum_w[W];
            if (v_w) begin
               flags_q.ovf <= 1'b1;
            end
         end
      end else if (phase_q == PH_T7 && link_in_shift) begin
         if (micro_q.ctl == CTL_SHIFT_LEFT_ONE) begin
            flags_q.link <= s_q[W-1];
         end else if (micro_q.ctl == CTL_SHIFT_RIGHT_ONE) begin
            flags_q.link <= s_q[0];
         end
      end
   end

   assign flags              = flags_q;
   assign general_flag_out   = flags_q.gen;
   assign carry_overflow_out = link_carry_select ? flags_q.carry : flags_q.ovf;

   // -------------------------------------------------------------------
   // Carry/shift lines
   // -------------------------------------------------------------------
   logic shift_win;

   assign shift_win = (phase_q == PH_T7) || (phase_q == PH_T8);

   always_comb begin
      upper_carry_shift_line_o  = 1'b0;
      upper_carry_shift_line_oe = 1'b0;
      lower_carry_shift_line_o  = 1'b0;
      lower_carry_shift_line_oe = 1'b0;
      if (phase_q == PH_T5) begin
         upper_carry_shift_line_o  = sum_w[W];
         upper_carry_shift_line_oe = 1'b1;
      end else if (shift_win && micro_q.ctl == CTL_SHIFT_LEFT_ONE) begin
         upper_carry_shift_line_o  = s_q[W-1];
         upper_carry_shift_line_oe = 1'b1;
      end else if (shift_win && micro_q.ctl == CTL_SHIFT_RIGHT_ONE) begin
         lower_carry_shift_line_o  = s_q[0];
         lower_carry_shift_line_oe = 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // External data lines, registered one interval ahead
   // -------------------------------------------------------------------
   // R-bus in T2, A-bus in T4, all ones in T5 and T6, released otherwise.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         external_data_lines_o  <= DATA_RST;
         external_data_lines_oe <= '0;
      end else begin
         unique case (phase_d)
            PH_T2: begin
               external_data_lines_o  <= r_q;
               external_data_lines_oe <= '1;
            end
            PH_T4: begin
               external_data_lines_o  <= a_q;
               external_data_lines_oe <= '1;
            end
            PH_T5, PH_T6: begin
               external_data_lines_o  <= '1;
               external_data_lines_oe <= '1;
            end
            default: begin
               external_data_lines_o  <= DATA_RST;
               external_data_lines_oe <= '0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb_main @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_shift_win;
      (phase_q == PH_T7) ##1 (phase_q == PH_T8);
   endsequence

   a_b_zero_fill: assert property ((phase_q == PH_T4 && micro_q.b_addr == '0)
      |=> b_q == '0) else $error("B-bus not zero for zero address");
   a_b_reg_select: assert property ((phase_q == PH_T4 && micro_q.b_addr != '0)
      |=> b_q == $past(rd_b)) else $error("B-bus lost register data");
   a_alu_add_result: assert property ((phase_q == PH_T5 && !cycle_start
      && control_bus_bits[1:0] == 2'h3) |=> s_q == $past(sum_w[W-1:0]))
      else $error("ADD result wrong");
   a_alu_and_comp: assert property ((phase_q == PH_T5 && !cycle_start
      && control_bus_bits[1:0] == 2'h0 && micro_q.comp_a)
      |=> s_q == ($past(~a_q) & $past(b_q))) else $error("complemented AND wrong");
   a_data_all_ones: assert property ((phase_q == PH_T5 || phase_q == PH_T6)
      |-> (external_data_lines_oe == '1 && external_data_lines_o == '1))
      else $error("data lines not high in T5/T6");
   a_carry_line_out: assert property ((phase_q == PH_T5) |-> (upper_carry_shift_line_oe
      && !lower_carry_shift_line_oe && upper_carry_shift_line_o == sum_w[W]))
      else $error("carry line wrong in T5");
   a_shift_left_out: assert property ((phase_q == PH_T7 && micro_q.ctl == CTL_SHIFT_LEFT_ONE
      && !cycle_start) |-> s_shift_win ##0 (upper_carry_shift_line_oe
      && upper_carry_shift_line_o == s_q[W-1]))
      else $error("left shift line not held through T8");
   a_push_top: assert property (do_push |=> stk_q[0] == $past(r_q))
      else $error("push lost R-bus value");
   a_reg_write: assert property ((phase_q == PH_T8 && r_addr_q != '0)
      |=> u_rf.mem_q[$past(r_addr_q)] == $past(r_q))
      else $error("register write missed");
   a_zero_result: assert property ((phase_q == PH_T8)
      |=> result_zero_n == ($past(r_q) != '0)) else $error("zero flag wrong");
   a_stack_full: assert property ((do_push && stk_q[DEPTH-2] != '0) |=> stack_full_out)
      else $error("stack full not raised");
   a_pop_clears_full: assert property (do_pop |=> !stack_full_out)
      else $error("stack full after pop");
   a_sign_fill_upper: assert property ((phase_q == PH_T7 && micro_q.ctl == CTL_SIGN_FILL
      && upper_byte_slice && control_bus_bits[CB_TOP]) |=> r_q == {W{$past(sign_q)}})
      else $error("sign fill wrong");

endmodule : bsl_slice

// [bsl_nbr_model.sv]
// Model of the neighbouring slices on the chained carry and shift lines.
module bsl_nbr_model (
   input  wire logic clk,
   input  wire logic en,
   input  wire logic up_bit,
   input  wire logic lo_bit,
   output logic      up_line,
   output logic      lo_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tog_q;
   initial tog_q = 1'b0;
   // Released lines toggle, so a stale bit can never pass for a real one.
   always @(posedge clk) begin
      tog_q <= ~tog_q;
   end
   // Carry in during T5, shift bits during T7 and T8; en drives both lines from T5 through T8, T6 included.
   assign up_line = en ? up_bit : tog_q;
   assign lo_line = en ? lo_bit : ~tog_q;
endmodule : bsl_nbr_model

// [bsl_slice_tb.sv]
// Self-checking testbench of the four-bit datapath slice.
module bsl_slice_tb;
   import bsl_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk, arst_n, ub, msb, fue, sgn, en, up, lo, sf, zn, co, su, sl, uo, low, ui, li;
   logic       cs, fsr, lcs, gf, uoe, loe;
   logic [3:0] cb, din, r, d5, e, dout, oe5;
   wire        sf_w, zn_w, co_w, gf_w, uoe_w, loe_w;
   wire  [3:0] oe_w;
   bsl_flags_t fl, flq;
   logic [3:0] tbl [4] = '{4'h1, 4'h6, 4'h7, 4'h8};
   int         error_cnt = 0;
   int         cmp_count = 0;
   int         cyc = 0;

   bsl_slice DUT (.clk(clk), .arst_n(arst_n), .cycle_start(cs), .control_bus_bits(cb),
      .msb_slice(msb), .upper_byte_slice(ub), .flag_update_en(fue),
      .link_carry_select(lcs), .flag_save_restore(fsr), .sign_input(sgn),
      .external_data_lines_i(din), .external_data_lines_o(dout),
      .external_data_lines_oe(oe_w), .upper_carry_shift_line_i(ui),
      .upper_carry_shift_line_o(uo), .upper_carry_shift_line_oe(uoe_w),
      .lower_carry_shift_line_i(li), .lower_carry_shift_line_o(low),
      .lower_carry_shift_line_oe(loe_w), .stack_full_out(sf_w), .result_zero_n(zn_w),
      .general_flag_out(gf_w), .carry_overflow_out(co_w), .flags(flq));

   bsl_nbr_model NBR (.clk(clk), .en(en), .up_bit(up), .lo_bit(lo), .up_line(ui), .lo_line(li));

   // Free-running clock and a cycle ceiling against hangs.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic chk(input logic [3:0] s, input logic [3:0] x);
      cmp_count++;
      if (s !== x) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, s, x);
      end
   endtask : chk

   // One microstep: four control words, outputs of the previous step caught in T2.
   task automatic step(input logic [3:0] w1, w3, w5, w7, x);
      for (int i = 0; i < 8; i++) begin
         cb <= i < 2 ? w1 : i < 4 ? w3 : i < 6 ? w5 : w7;
         din <= x;
         en <= (i >= 4);
         @(negedge clk);
         if (i == 1) begin
            r = dout;
            sf = sf_w;
            zn = zn_w;
            fl = flq;
            co = co_w;
            gf = gf_w;
         end
         if (i == 4) {d5, oe5} = {dout, oe_w};
         if (i == 6) {su, sl, uoe, loe} = {uo, low, uoe_w, loe_w};
         @(posedge clk);
      end
      chk(d5, 4'hF);
      chk(oe5, 4'hF);
   endtask : step

   task automatic go(input logic [3:0] w1, w3, w5, w7, x, nx);
      step(w1, w3, w5, w7, x);
      chk(r, e);
      e = nx;
   endtask : go

   task automatic wrap_up();
      if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up

   // Main sequence; R-bus, flag and stack checks judge the step before, shift-line checks the step just run.
   initial begin
      {arst_n, ub, msb, fue, en, up, lo, fsr, lcs} = '0;
      {cb, din, e} = '0;
      cs = 1'b1;
      sgn = 1'b1;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      // Holding the cycle start parks the slice in T1; a leak would misalign every step.
      repeat (3) @(posedge clk);
      cs <= 1'b0;
      step(4'h0, 4'h0, 4'h0, 4'h9, 4'h5);
      e = 4'h5;
      go(4'h0, 4'h0, 4'h0, 4'hA, 4'h3, 4'h3);
      for (int k = 0; k < 4; k++) go(4'h1, 4'h2, 4'(k), 4'h0, 4'h0, tbl[k]);
      go(4'h1, 4'hA, 4'h0, 4'h0, 4'h0, 4'h2);
      go(4'h1, 4'h0, 4'h2, 4'h0, 4'h0, 4'h5);
      go(4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0);
      lo <= 1'b1;
      go(4'h1, 4'h0, 4'hA, 4'h0, 4'h0, 4'hB);
      chk({3'h0, zn}, 4'h0);
      chk({3'h0, su}, 4'h0);
      chk({2'h0, uoe, loe}, 4'h2);
      {lo, up} <= 2'b01;
      go(4'h1, 4'h0, 4'hE, 4'h0, 4'h0, 4'hA);
      chk({3'h0, sl}, 4'h1);
      chk({2'h0, uoe, loe}, 4'h1);
      up <= 1'b0;
      repeat (16) go(4'h9, 4'h0, 4'h2, 4'h0, 4'h0, 4'h5);
      go(4'h8, 4'h0, 4'h2, 4'h1, 4'h0, 4'h5);
      chk({3'h0, sf}, 4'h1);
      ub <= 1'b1;
      go(4'h0, 4'h0, 4'h4, 4'h8, 4'h0, 4'hF);
      chk({3'h0, sf}, 4'h0);
      {ub, fsr} <= 2'b01;
      go(4'h0, 4'h0, 4'h0, 4'h8, 4'h9, 4'h9);
      go(4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h9);
      chk(fl, 4'h9);
      chk({3'h0, gf}, 4'h1);
      {fsr, lcs, msb} <= 3'b011;
      go(4'h1, 4'h0, 4'hE, 4'h0, 4'h0, 4'hA);
      {lcs, fue} <= 2'b01;
      go(4'h1, 4'h2, 4'h3, 4'h0, 4'h0, 4'h8);
      lo <= 1'b1;
      go(4'h1, 4'h9, 4'h3, 4'h0, 4'h0, 4'h0);
      chk({3'h0, fl.ovf}, 4'h1);
      chk({3'h0, co}, 4'h1);
      chk({3'h0, fl.carry}, 4'h0);
      go(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
      chk({3'h0, fl.carry}, 4'h1);
      chk({3'h0, zn}, 4'h0);
      wrap_up();
   end
endmodule : bsl_slice_tb
